//--- hdl/sgwl_device.sv
// Device end: samples the serial link and holds the applied gain code
`timescale 1ns/1ps
`include "sgwl_regs.svh"
module sgwl_device #(
  parameter int BOOT_CYC = `SGWL_BOOT_CYC,
  parameter int SYNC_LAT = `SGWL_SYNC_LAT
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  sgwl_if.dev link,
  output sgwl_pkg::sgwl_code_t gain_code_o,
  output logic [15:0] gain_mvv_o,
  output logic drive_en_o,
  output logic out_settled_o,
  output logic word_done_o,
  output logic word_short_o
);
  import sgwl_pkg::*;

  localparam int SET_W = 12;
  localparam logic [SET_W-1:0] APPLY_CNT = SET_W'(`SGWL_APPLY_CYC);
  localparam logic [SET_W-1:0] SLEEP_CNT = SET_W'(`SGWL_SLEEP_CYC);
  localparam logic [SET_W-1:0] BOOT_CNT = SET_W'(BOOT_CYC);
  localparam logic [3:0] STRAP_AT = 4'(SYNC_LAT);

  // The settle counter and boot timer are sized here; larger values would wrap
  initial
  begin
    if (BOOT_CYC < 1 || BOOT_CYC > 4095)
      $error("sgwl_device: BOOT_CYC out of range");
    if (SYNC_LAT < 3 || SYNC_LAT > 15)
      $error("sgwl_device: SYNC_LAT out of range");
  end

  // Pin order in the synchroniser vectors
  localparam int P_WIN = 0;
  localparam int P_CLK = 1;
  localparam int P_DAT = 2;
  localparam int P_SLP = 3;

  // Idle level of each pin, so no false edge follows reset on an idle link
  localparam logic [3:0] PIN_IDLE = 4'h9;

  logic [3:0] pin_raw;
  logic [3:0] meta_q;
  logic [3:0] stab_q;
  logic [3:0] prev_q;

  assign pin_raw = {link.sleep_n, link.serial_gain_in, link.sclk, link.load_window_n};

  // Two-flop synchroniser per pin plus an edge flop; only the second and third stages feed logic
  for (genvar i = 0; i < 4; i++)
  begin : g_sync
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        meta_q[i] <= PIN_IDLE[i];
        stab_q[i] <= PIN_IDLE[i];
        prev_q[i] <= PIN_IDLE[i];
      end
      else
      begin
        meta_q[i] <= pin_raw[i];
        stab_q[i] <= meta_q[i];
        prev_q[i] <= stab_q[i];
      end
    end
  end

  // Edge decode on the settled copies
  wire win_fall = prev_q[P_WIN] & ~stab_q[P_WIN];
  wire win_rise = ~prev_q[P_WIN] & stab_q[P_WIN];
  wire sclk_fall = prev_q[P_CLK] & ~stab_q[P_CLK];
  wire sleep_rise = ~prev_q[P_SLP] & stab_q[P_SLP];
  wire sleep_on = stab_q[P_SLP];

  sgwl_dev_state_t state_q;
  sgwl_dev_state_t state_d;
  logic [3:0] boot_q;
  logic [3:0] boot_d;
  logic shift_en_q;
  logic shift_en_d;
  logic [7:0] shreg_q;
  logic [7:0] shreg_d;
  logic [3:0] bits_q;
  logic [3:0] bits_d;
  sgwl_code_t gain_q;
  sgwl_code_t gain_d;
  logic [SET_W-1:0] settle_q;
  logic [SET_W-1:0] settle_d;
  logic [15:0] mvv_q;
  logic drive_q;
  logic settled_q;
  logic done_q;
  logic short_q;
  logic short_d;

  // Boot: wait until the synchronised window level is trustworthy, then read it
  wire boot_strap = (state_q == SGWL_D_BOOT) && (boot_q == STRAP_AT);
  wire strap_min = boot_strap & ~stab_q[P_WIN];
  assign state_d = boot_strap ? SGWL_D_RUN : state_q;
  assign boot_d = (state_q == SGWL_D_BOOT) ? boot_q + 4'h1 : boot_q;

  // Shift clock runs only inside a window that began with a fall
  wire running = (state_q == SGWL_D_RUN);
  // Only a window opened after boot counts, so the strap release is not taken as a word
  wire word_open = running & win_fall;
  wire apply = running & win_rise & shift_en_q;
  wire take_bit = running & shift_en_q & sclk_fall & ~stab_q[P_WIN];
  assign shift_en_d = word_open ? 1'b1 : (win_rise ? 1'b0 : shift_en_q);
  assign shreg_d = take_bit ? {shreg_q[6:0], stab_q[P_DAT]} : shreg_q;
  assign bits_d = win_fall ? 4'h0 : ((take_bit && bits_q != 4'hF) ? bits_q + 4'h1 : bits_q);

  // Gain latch: loaded at the window rise, or with the minimum at the boot strap, held otherwise
  always_comb
  begin
    gain_d = gain_q;
    if (strap_min)
      gain_d = `SGWL_GAIN_MIN;
    else if (apply)
      gain_d = shreg_q;
  end

  // A window that closed without exactly eight bits is flagged but still applied
  assign short_d = apply ? (bits_q != `SGWL_WORD_BITS) : short_q;

  // Settle timer: longest pending settle time wins
  always_comb
  begin
    settle_d = (settle_q != '0) ? settle_q - 1'b1 : settle_q;
    if (strap_min)
      settle_d = BOOT_CNT;
    else if (sleep_rise && settle_d < SLEEP_CNT)
      settle_d = SLEEP_CNT;
    else if (apply && settle_d < APPLY_CNT)
      settle_d = APPLY_CNT;
  end

  // Linear gain in thousandths of V/V
  wire [15:0] mvv_d = 16'(`SGWL_GAIN_SLOPE * {8'h00, gain_q}) + `SGWL_GAIN_OFS;

  // Control and data state
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= SGWL_D_BOOT;
      boot_q <= 4'h0;
      shift_en_q <= 1'b0;
      shreg_q <= 8'h00;
      bits_q <= 4'h0;
      gain_q <= `SGWL_GAIN_RESET;
      short_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      boot_q <= boot_d;
      shift_en_q <= shift_en_d;
      shreg_q <= shreg_d;
      bits_q <= bits_d;
      gain_q <= gain_d;
      short_q <= short_d;
    end
  end

  // Status and scaled gain
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      settle_q <= '0;
      mvv_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else
    begin
      settle_q <= settle_d;
      mvv_q <= mvv_d;
      done_q <= apply;
    end
  end

  // Sleep pin clears the drive flop directly, no clock edge needed
  // Hazard: a glitch on the pin also drops drive; re-enable goes via the synchroniser
  wire drive_rst_n = rst_n_i & link.sleep_n;
  wire drive_d = running & sleep_on;

  always_ff @(posedge core_clk_i or negedge drive_rst_n)
  begin
    if (!drive_rst_n)
      drive_q <= 1'b0;
    else
      drive_q <= drive_d;
  end

  // Settled only when driving and all settle times have run out
  wire settled_d = drive_q & drive_d & (settle_d == '0);

  always_ff @(posedge core_clk_i or negedge drive_rst_n)
  begin
    if (!drive_rst_n)
      settled_q <= 1'b0;
    else
      settled_q <= settled_d;
  end

  // Outputs straight from flops
  assign gain_code_o = gain_q;
  assign gain_mvv_o = mvv_q;
  assign drive_en_o = drive_q;
  assign out_settled_o = settled_q;
  assign word_done_o = done_q;
  assign word_short_o = short_q;
endmodule

//--- hdl/sgwl_host.sv
// Host end: serialises gain words and drives the sleep line
`timescale 1ns/1ps
`include "sgwl_regs.svh"
module sgwl_host #(
  parameter int SCLK_HALF = `SGWL_SCLK_HALF,
  parameter int BOOT_HOLD = `SGWL_BOOT_HOLD,
  parameter bit BOOT_MIN_GAIN = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  sgwl_if.host link,
  input wire logic wr_req_i,
  input sgwl_pkg::sgwl_code_t wr_gain_i,
  input wire logic sleep_req_i,
  output logic busy_o,
  output logic done_o
);
  import sgwl_pkg::*;

  // The phase counter is eight bits wide
  initial
  begin
    if (SCLK_HALF < 1 || SCLK_HALF > 255)
      $error("sgwl_host: SCLK_HALF out of range");
    if (BOOT_HOLD < 1 || BOOT_HOLD > 255)
      $error("sgwl_host: BOOT_HOLD out of range");
  end

  localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);
  localparam logic [7:0] HOLD_M1 = 8'(BOOT_HOLD - 1);

  sgwl_host_state_t state_q;
  logic [7:0] cnt_q;
  logic [3:0] bits_q;
  logic [7:0] sh_q;
  logic win_n_q;
  logic sclk_q;
  logic dat_q;
  logic sleep_n_q;
  logic busy_q;
  logic done_q;

  wire tick = (cnt_q == 8'h00);
  wire last_bit = (bits_q == `SGWL_WORD_BITS);

  // Sleep line follows the user request, writes stay allowed meanwhile
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sleep_n_q <= 1'b1;
    else
      sleep_n_q <= ~sleep_req_i;
  end

  // Write sequencer; serial clock idles low outside a write to cut feedthrough
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= SGWL_H_BOOT;
      cnt_q <= HOLD_M1;
      bits_q <= 4'h0;
      sh_q <= 8'h00;
      win_n_q <= ~BOOT_MIN_GAIN;
      sclk_q <= 1'b0;
      dat_q <= 1'b0;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      cnt_q <= tick ? HALF_M1 : cnt_q - 8'h01;
      case (state_q)
        SGWL_H_BOOT:
          if (tick)
          begin
            win_n_q <= 1'b1;
            busy_q <= 1'b0;
            state_q <= SGWL_H_IDLE;
          end
        SGWL_H_IDLE:
          if (wr_req_i)
          begin
            sh_q <= wr_gain_i;
            win_n_q <= 1'b0;
            busy_q <= 1'b1;
            cnt_q <= HALF_M1;
            state_q <= SGWL_H_LEAD;
          end
        SGWL_H_LEAD:
          if (tick)
          begin
            dat_q <= sh_q[7];
            sh_q <= {sh_q[6:0], 1'b0};
            sclk_q <= 1'b1;
            bits_q <= 4'h0;
            state_q <= SGWL_H_HIGH;
          end
        SGWL_H_HIGH:
          if (tick)
          begin
            sclk_q <= 1'b0;
            bits_q <= bits_q + 4'h1;
            state_q <= SGWL_H_LOW;
          end
        SGWL_H_LOW:
          if (tick)
          begin
            if (last_bit)
              state_q <= SGWL_H_TRAIL;
            else
            begin
              dat_q <= sh_q[7];
              sh_q <= {sh_q[6:0], 1'b0};
              sclk_q <= 1'b1;
              state_q <= SGWL_H_HIGH;
            end
          end
        SGWL_H_TRAIL:
          if (tick)
          begin
            win_n_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= SGWL_H_IDLE;
          end
        default:
          state_q <= SGWL_H_IDLE;
      endcase
    end
  end

  // Link and user outputs straight from flops
  assign link.load_window_n = win_n_q;
  assign link.sclk = sclk_q;
  assign link.serial_gain_in = dat_q;
  assign link.sleep_n = sleep_n_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
endmodule

//--- hdl/sgwl_if.sv
// Three-wire gain load link plus sleep line between host and device
`timescale 1ns/1ps
interface sgwl_if;
  logic load_window_n;
  logic sclk;
  logic serial_gain_in;
  logic sleep_n;

  modport dev (
    input load_window_n,
    input sclk,
    input serial_gain_in,
    input sleep_n
  );

  modport host (
    output load_window_n,
    output sclk,
    output serial_gain_in,
    output sleep_n
  );
endinterface

//--- hdl/sgwl_pkg.sv
// Types shared by both ends of the serial gain word loader
package sgwl_pkg;
  typedef logic [7:0] sgwl_code_t;
  typedef enum logic {SGWL_D_BOOT, SGWL_D_RUN} sgwl_dev_state_t;
  typedef enum logic [2:0] {
    SGWL_H_BOOT,
    SGWL_H_IDLE,
    SGWL_H_LEAD,
    SGWL_H_HIGH,
    SGWL_H_LOW,
    SGWL_H_TRAIL
  } sgwl_host_state_t;
endpackage

//--- hdl/sgwl_regs.svh
// Constants for the serial gain word loader, both ends
`ifndef SGWL_REGS_SVH
`define SGWL_REGS_SVH

`define SGWL_CLK_NS 100
`define SGWL_WORD_BITS 4'h8
`define SGWL_GAIN_RESET 8'h00
`define SGWL_GAIN_MIN 8'h00
`define SGWL_GAIN_SLOPE 16'h004D
`define SGWL_GAIN_OFS 16'h013C
`define SGWL_APPLY_NS 30
`define SGWL_SLEEP_NS 45
`define SGWL_BOOT_US 200
`define SGWL_APPLY_CYC (((`SGWL_APPLY_NS / `SGWL_CLK_NS) > 0) ? (`SGWL_APPLY_NS / `SGWL_CLK_NS) : 1)
`define SGWL_SLEEP_CYC (((`SGWL_SLEEP_NS / `SGWL_CLK_NS) > 0) ? (`SGWL_SLEEP_NS / `SGWL_CLK_NS) : 1)
`define SGWL_BOOT_CYC ((`SGWL_BOOT_US * 1000) / `SGWL_CLK_NS)
`define SGWL_SYNC_LAT 3
`define SGWL_SCLK_HALF 4
`define SGWL_BOOT_HOLD 8

`endif

//--- verification/serial_gain_word_loader_tb.sv
// Bench: host and device back to back, plus a device fed by a faulty host
`timescale 1ns/1ps
module serial_gain_word_loader_tb;
  import sgwl_pkg::*;
  typedef struct packed {sgwl_code_t code; logic [15:0] mvv;} sgwl_row_t;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_req_i = 1'b0;
  logic sleep_req_i = 1'b0;
  sgwl_code_t wr_gain_i = 8'h00;
  sgwl_code_t prev = 8'h00;
  sgwl_code_t gain_a;
  sgwl_code_t gain_b;
  logic [15:0] mvv_a;
  logic busy_o;
  logic done_o;
  logic en_a;
  logic set_a;
  logic short_a;
  logic done_a;
  logic short_b;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  sgwl_row_t rows [6] = '{'{8'h00, 16'h013C}, '{8'hFF, 16'h4DEF}, '{8'hA5, 16'h32DD},
    '{8'h5A, 16'h1C4E}, '{8'h01, 16'h0189}, '{8'h80, 16'h27BC}};
  sgwl_if link_a ();
  sgwl_if link_b ();

  sgwl_host sgwl_host_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link_a), .wr_req_i(wr_req_i),
    .wr_gain_i(wr_gain_i), .sleep_req_i(sleep_req_i), .busy_o(busy_o), .done_o(done_o));
  sgwl_device #(.BOOT_CYC(20)) sgwl_device_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link_a), .gain_code_o(gain_a),
    .gain_mvv_o(mvv_a), .drive_en_o(en_a), .out_settled_o(set_a), .word_done_o(done_a),
    .word_short_o(short_a));
  // Second device faces the bench, which breaks the word length on purpose
  sgwl_device #(.BOOT_CYC(20)) sgwl_device_b_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link_b), .gain_code_o(gain_b),
    .gain_mvv_o(), .drive_en_o(), .out_settled_o(), .word_done_o(), .word_short_o(short_b));
  sgwl_chk sgwl_chk_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .load_window_n(link_a.load_window_n), .sclk(link_a.sclk),
    .serial_gain_in(link_a.serial_gain_in), .sleep_n(link_a.sleep_n));

  always #50 core_clk_i = ~core_clk_i;

  // Cut a hang short well past the expected run of about 900 cycles
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // One host write; the old code must stand while the window is open
  task automatic write(input sgwl_code_t code, input logic [15:0] mvv);
    wr_gain_i = code;
    wr_req_i = 1'b1;
    tick(1);
    wr_req_i = 1'b0;
    tick(30);
    check(16'(gain_a), 16'(prev));
    for (int i = 0; i < 100 && done_o !== 1'b1; i++)
      tick(1);
    check(16'(done_o), 16'h0001);
    tick(3);
    check(16'(done_a), 16'h0001);
    tick(3);
    check(16'(gain_a), 16'(code));
    check(mvv_a, mvv);
    check(16'(short_a), 16'h0000);
    prev = code;
  endtask

  // Faulty host: n bits, top bit first, link clock of 800 ns made here
  task automatic send_b(input int n, input logic [15:0] bits);
    link_b.load_window_n = 1'b0;
    #400;
    for (int i = n - 1; i >= 0; i--)
    begin
      link_b.serial_gain_in = bits[i];
      link_b.sclk = 1'b1;
      #400;
      link_b.sclk = 1'b0;
      #400;
    end
    // Close two low phases after the last fall, so the last bit lands first
    #400;
    link_b.load_window_n = 1'b1;
    link_b.serial_gain_in = ~link_b.serial_gain_in;
    tick(8);
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    link_b.load_window_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.serial_gain_in = 1'b0;
    link_b.sleep_n = 1'b1;
    tick(5);
    rst_n_i = 1'b1;
    tick(4);
    check(16'(gain_a), 16'h0000);
    check(16'(set_a), 16'h0000);
    for (int i = 0; i < 50 && busy_o !== 1'b0; i++)
      tick(1);
    tick(30);
    check(16'(set_a), 16'h0001);
    $display("boot test done");
    for (int r = 0; r < 6; r++)
      write(rows[r].code, rows[r].mvv);
    $display("row test done");
    sleep_req_i = 1'b1;
    @(negedge link_a.sleep_n);
    #1;
    check(16'(en_a), 16'h0000);
    check(16'(set_a), 16'h0000);
    check(16'(gain_a), 16'(prev));
    write(8'h3C, 16'h1348);
    check(16'(en_a), 16'h0000);
    sleep_req_i = 1'b0;
    tick(7);
    check(16'(en_a), 16'h0001);
    check(16'(set_a), 16'h0001);
    check(16'(gain_a), 16'h003C);
    $display("sleep test done");
    send_b(7, 16'h0055);
    check(16'(short_b), 16'h0001);
    send_b(8, 16'h00C3);
    check(16'(gain_b), 16'h00C3);
    check(16'(short_b), 16'h0000);
    send_b(9, 16'h01A5);
    check(16'(gain_b), 16'h00A5);
    check(16'(short_b), 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      link_b.serial_gain_in = ~link_b.serial_gain_in;
      link_b.sclk = 1'b1;
      #400;
      link_b.sclk = 1'b0;
      #400;
    end
    // An empty window applies the shift register, which stray pulses must not have moved
    send_b(0, 16'h0000);
    check(16'(gain_b), 16'h00A5);
    check(16'(short_b), 16'h0001);
    $display("fault test done");
    conclude();
  end
endmodule

//--- verification/sgwl_chk.sv
// Concurrent checks on the host side of the gain load link
`timescale 1ns/1ps
module sgwl_chk (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic load_window_n,
  input wire logic sclk,
  input wire logic serial_gain_in,
  input wire logic sleep_n
);
  logic in_word_q;
  logic [3:0] rises_q;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Count pulses only inside a window opened by a fall, so the boot strap is not a word
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      in_word_q <= 1'b0;
      rises_q <= 4'h0;
    end
    else if ($fell(load_window_n))
    begin
      in_word_q <= 1'b1;
      rises_q <= 4'h0;
    end
    else
    begin
      if ($rose(load_window_n))
        in_word_q <= 1'b0;
      if ($rose(sclk) && in_word_q)
        rises_q <= rises_q + 4'h1;
    end
  end

  // Host timing as the contract walks it, with the default divider
  property p_sclk_idle;
    load_window_n |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock runs outside window");
  property p_data_hold;
    $fell(sclk) |-> $stable(serial_gain_in);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved at clock fall");
  property p_high_len;
    $rose(sclk) |-> sclk [*4] ##1 !sclk;
  endproperty
  a_high_len: assert property (p_high_len) else $error("clock high phase wrong");
  property p_low_len;
    $fell(sclk) |-> !sclk [*4];
  endproperty
  a_low_len: assert property (p_low_len) else $error("clock low phase short");
  property p_eight;
    $rose(load_window_n) && in_word_q |-> rises_q == 4'h8;
  endproperty
  a_eight: assert property (p_eight) else $error("word did not hold eight pulses");
  property p_lead;
    $fell(load_window_n) |-> !sclk [*4] ##1 sclk;
  endproperty
  a_lead: assert property (p_lead) else $error("first pulse not four cycles after fall");
  property p_last;
    $fell(sclk) && in_word_q && rises_q == 4'h8 |-> ##8 $rose(load_window_n);
  endproperty
  a_last: assert property (p_last) else $error("window not closed after last bit");
  property p_word_len;
    $fell(load_window_n) |-> ##72 $rose(load_window_n);
  endproperty
  a_word_len: assert property (p_word_len) else $error("word length wrong");

  c_write: cover property ($rose(load_window_n) && in_word_q);
  c_sleep: cover property ($fell(sleep_n));
  c_sleep_word: cover property (!sleep_n && $fell(load_window_n));
endmodule
